//--- dce_ctrl_model.sv
// Purpose: safety controller side that reads the process input image
// Assumes: image and interrupt are synchronous to sys_clk
// Notes: also derives the discrepancy time from a response time budget
module dce_ctrl_model #(
	parameter int RESP_MS = 60,
	parameter int CYCLE_MS = 10,
	parameter int SMOOTH = 1
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [15:0] process_input_image,
	input wire logic diag_irq,
	output logic [15:0] disc_time_ms,
	output logic [7:0] irq_count,
	output logic [15:0] last_value
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// configuration
	// budget minus smoothing delay and two conversion cycles
	assign disc_time_ms = 16'(RESP_MS - 2 * CYCLE_MS * SMOOTH
		- 2 * CYCLE_MS);
	// ==========================================================
	// image reader
	// latch the image each cycle; tally interrupts, never miss a pulse
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			irq_count <= 8'h00;
			last_value <= 16'h0000;
		end else begin
			last_value <= process_input_image;
			irq_count <= irq_count + 8'(diag_irq);
		end
	end
endmodule

//--- dce_eval.sv
// Purpose: discrepancy evaluator for one redundant current input pair
// Assumes: samples in uA, synchronous to sys_clk
// Notes: results feed the process input image of the safety controller
// Notes on behaviour
// - a discrepancy outlasting the configured time becomes an error.
// - an error pulses the diagnostic interrupt and reports 7fff.
// - returning inside the window clears the running timer.
// - the configured time is rounded to whole 10 ms steps.
// - zero time stays zero, small nonzero times rise to the minimum.
// - while the discrepancy time runs, the last good selected value is held.
// - a per-pair bit picks the lower or the higher channel.
// - absolute deviation is span times percent over 100.
// - relative deviation is percent of selected value minus range start.
// - both tolerance percentages are held within 0.2 to 20 percent.
// - with both tolerances on, the larger deviation is the window.
// - the pair keeps its own time, selection and two tolerances.
// - discrepant after startup or a channel fault reports 7fff and times.
// - channel values are averaged over 1, 4, 16 or 64 conversions.
// - agreement at expiry reports the value and holds a fault until ack.
module dce_eval import dce_pkg::*; (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic [15:0] sample_a,
	input wire logic [15:0] sample_b,
	input wire logic channel_fault,
	output logic [15:0] process_input_image,
	output logic diag_irq,
	output logic fault_held
);
	dce_smooth_if sm ();

	dce_smoother u_smooth (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.sample_valid(sample_valid),
		.sample_a(sample_a),
		.sample_b(sample_b),
		.sm(sm)
	);

	// ==========================================================
	// registers
	logic [15:0] time_ms, ctrl, tol, next_time_ms, next_ctrl, next_tol;
	logic [15:0] rdata, next_rdata;
	logic [11:0] lim_ticks, next_lim_ticks;
	logic [15:0] rnd;

	// round to 10 ms steps and clamp small values
	always_comb begin
		next_time_ms = time_ms;
		next_ctrl = ctrl;
		next_tol = tol;
		rnd = (time_ms > 16'(MAX_TIME_MS)) ? 16'(MAX_TIME_MS) : time_ms;
		next_lim_ticks = 12'((rnd + 16'h0005) / 16'(TICK_MS));
		if (time_ms != 16'h0000 && next_lim_ticks < MIN_TICKS) begin
			next_lim_ticks = MIN_TICKS;
		end
		if (reg_wr) begin
			case (reg_addr)
				OFS_TIME: next_time_ms = reg_wdata;
				OFS_CTRL: next_ctrl = reg_wdata;
				OFS_TOL: next_tol = {dce_clip(reg_wdata[15:8]),
					dce_clip(reg_wdata[7:0])};
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			time_ms <= TIME_RST;
			ctrl <= CTRL_RST;
			tol <= TOL_RST;
			// matches the reset time so the limit does not lag the setting out of reset
			lim_ticks <= 12'((TIME_RST + 16'h0005) / 16'(TICK_MS));
			rdata <= '0;
		end else begin
			time_ms <= next_time_ms;
			ctrl <= next_ctrl;
			tol <= next_tol;
			lim_ticks <= next_lim_ticks;
			rdata <= next_rdata;
		end
	end

	// ==========================================================
	// selection and tolerance window
	logic [15:0] sel, other, start, diff, dabs, drel, dwin;
	logic outside;
	always_comb begin
		if (ctrl[CTRL_SEL_MAX] == (sm.avg_a >= sm.avg_b)) begin
			sel = sm.avg_a;
			other = sm.avg_b;
		end else begin
			sel = sm.avg_b;
			other = sm.avg_a;
		end
		start = ctrl[CTRL_RANGE4] ? START_4MA : 16'h0000;
		diff = (sel > other) ? sel - other : other - sel;
		dabs = dce_dev(RANGE_END_CURRENT - start,
			tol[TOL_ABS_LSB +: 8]);
		drel = dce_dev((sel > start) ? sel - start : start - sel,
			tol[TOL_REL_LSB +: 8]);
		if (!ctrl[CTRL_ABS_EN]) begin
			dabs = '0;
		end
		if (!ctrl[CTRL_REL_EN]) begin
			drel = '0;
		end
		dwin = (dabs > drel) ? dabs : drel;
		outside = diff > dwin;
	end
	assign sm.depth = ctrl[CTRL_SMOOTH +: 2];
	assign sm.restart = channel_fault;

	// ==========================================================
	// 10 ms tick divider
	logic [19:0] div, next_div;
	logic tick;
	always_comb begin
		tick = div == 20'(TICK_CYCLES - 1);
		next_div = tick ? '0 : div + 20'h00001;
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			div <= '0;
		end else begin
			div <= next_div;
		end
	end

	// ==========================================================
	// discrepancy state machine; fresh marks startup or post-fault
	dce_state_t st, next_st;
	logic [11:0] ticks, next_ticks;
	logic [15:0] piv, next_piv, held, next_held;
	logic fresh, next_fresh, irq, next_irq, flt, next_flt;
	logic ack;
	logic expire;
	assign ack = reg_wr && reg_addr == OFS_ACK;
	assign expire = (ticks >= lim_ticks);

	always_comb begin
		next_st = st;
		next_ticks = ticks;
		next_piv = piv;
		next_held = held;
		next_fresh = fresh;
		next_irq = 1'b0;
		next_flt = flt;
		if (ack) begin
			next_flt = 1'b0;
		end
		if (channel_fault) begin
			next_fresh = 1'b1;
			next_st = DCE_AGREE;
			next_ticks = '0;
			next_piv = ERROR_CODE;
		end else if (sm.avg_valid) begin
			case (st)
				DCE_AGREE: begin
					if (outside) begin
						next_st = DCE_TIMING;
						next_ticks = '0;
						if (fresh) begin
							next_piv = ERROR_CODE;
						end
					end else begin
						next_held = sel;
						next_piv = sel;
						next_fresh = 1'b0;
					end
				end
				DCE_TIMING: begin
					if (!outside) begin
						next_st = DCE_AGREE;
						next_ticks = '0;
						next_held = sel;
						next_piv = sel;
						next_fresh = 1'b0;
					end else begin
						next_piv = fresh ? ERROR_CODE : held;
					end
				end
				DCE_ERROR: begin
					if (!outside) begin
						next_st = DCE_AGREE;
						next_held = sel;
						next_piv = sel;
						next_fresh = 1'b0;
					end
				end
				default: next_st = DCE_AGREE;
			endcase
		end
		if (!channel_fault && st == DCE_TIMING && next_st == DCE_TIMING) begin
			if (tick && !expire) begin
				next_ticks = ticks + 12'h001;
			end
			if (expire) begin
				next_ticks = '0;
				next_flt = 1'b1;
				next_irq = 1'b1;
				if (outside) begin
					next_st = DCE_ERROR;
					next_piv = ERROR_CODE;
				end else begin
					next_st = DCE_AGREE;
					next_piv = sel;
					next_held = sel;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st <= DCE_AGREE;
			ticks <= '0;
			piv <= ERROR_CODE;
			held <= '0;
			fresh <= 1'b1;
			irq <= 1'b0;
			flt <= 1'b0;
		end else begin
			st <= next_st;
			ticks <= next_ticks;
			piv <= next_piv;
			held <= next_held;
			fresh <= next_fresh;
			irq <= next_irq;
			flt <= next_flt;
		end
	end

	// ==========================================================
	// read port: data stand one cycle after the strobe
	always_comb begin
		next_rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				OFS_TIME: next_rdata = time_ms;
				OFS_CTRL: next_rdata = ctrl;
				OFS_TOL: next_rdata = tol;
				OFS_STAT: next_rdata = {12'h000, flt, fresh, st};
				OFS_VALUE: next_rdata = piv;
				default: next_rdata = '0;
			endcase
		end
	end

	assign reg_rdata = rdata;
	assign process_input_image = piv;
	assign diag_irq = irq;
	assign fault_held = flt;

	// ==========================================================
	// checks
	sequence timing_s;
		st == DCE_TIMING;
	endsequence

	err_code_out_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st == DCE_ERROR |-> piv == ERROR_CODE)
		else $error("error state without error code");
	err_irq_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(st == DCE_ERROR) |-> irq && flt)
		else $error("error without interrupt");
	clear_timer_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		timing_s ##1 st == DCE_AGREE |-> ticks == 12'h000)
		else $error("timer not cleared");
	zero_time_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$past(time_ms) == 16'h0000 |-> lim_ticks == 12'h000)
		else $error("zero time altered");
	small_time_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$past(time_ms) != 16'h0000 |-> lim_ticks >= MIN_TICKS)
		else $error("small time not raised");
	hold_value_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		timing_s ##1 (st == DCE_TIMING && !fresh && !channel_fault
		&& !$past(channel_fault)) |-> piv == held)
		else $error("held value not reported");
	tol_range_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		tol[7:0] >= TOL_MIN && tol[7:0] <= TOL_MAX
		&& tol[15:8] >= TOL_MIN && tol[15:8] <= TOL_MAX)
		else $error("tolerance out of range");
	win_max_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		dwin >= dabs && dwin >= drel)
		else $error("window not the larger deviation");
	fault_start_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		channel_fault |=> piv == ERROR_CODE && fresh)
		else $error("fault did not force error code");
	tick_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st == DCE_TIMING && !tick ##1 st == DCE_TIMING
		|-> $stable(ticks))
		else $error("timer moved without tick");
endmodule

//--- dce_pkg.sv
// Purpose: constants and types shared by the discrepancy evaluator files
// Assumes: 10 MHz system clock, 16-bit process values, currents in uA
// Notes: one channel pair per instance of the top module
package dce_pkg;
	// ==========================================================
	// clock and timer
	localparam int CLK_HZ = 10000000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam logic [14:0] MAX_TIME_MS = 15'h7530; // 30000 ms
	localparam logic [11:0] MIN_TICKS = 12'h002; // least nonzero timer
	// ==========================================================
	// register offsets (plain port, word addressed)
	localparam logic [3:0] OFS_TIME = 4'h0;
	localparam logic [3:0] OFS_CTRL = 4'h1;
	localparam logic [3:0] OFS_TOL = 4'h2;
	localparam logic [3:0] OFS_STAT = 4'h3;
	localparam logic [3:0] OFS_VALUE = 4'h4;
	localparam logic [3:0] OFS_ACK = 4'h5;
	// ctrl fields
	localparam int CTRL_SEL_MAX = 0;
	localparam int CTRL_RANGE4 = 1;
	localparam int CTRL_ABS_EN = 2;
	localparam int CTRL_REL_EN = 3;
	localparam int CTRL_SMOOTH = 4; // two bits: 1,4,16,64
	// tol fields: tenths of a percent, 2..200
	localparam int TOL_ABS_LSB = 0;
	localparam int TOL_REL_LSB = 8;
	localparam logic [7:0] TOL_MIN = 8'h02;
	localparam logic [7:0] TOL_MAX = 8'hc8;
	// reset values
	localparam logic [15:0] TIME_RST = 16'h0096; // 150 ms
	localparam logic [15:0] CTRL_RST = 16'h000e;
	localparam logic [15:0] TOL_RST = 16'h1919; // 2.5 %
	// ==========================================================
	// currents in uA
	localparam logic [15:0] RANGE_END_CURRENT = 16'h4e20; // 20 mA
	localparam logic [15:0] START_4MA = 16'h0fa0;
	localparam logic [15:0] ERROR_CODE = 16'h7fff;
	localparam logic [15:0] PCT_DIV = 16'h03e8; // 100 % in tenths

	typedef enum logic [1:0] {
		DCE_AGREE = 2'b00,
		DCE_TIMING = 2'b01,
		DCE_ERROR = 2'b11
	} dce_state_t;

	// tolerance deviation: span times tenths of percent over 1000
	function automatic logic [15:0] dce_dev(input logic [15:0] span,
		input logic [7:0] pct);
		logic [23:0] prod;
		prod = 24'(span) * 24'(pct);
		return 16'(prod / 24'(PCT_DIV));
	endfunction

	function automatic logic [7:0] dce_clip(input logic [7:0] t);
		return (t < TOL_MIN) ? TOL_MIN : ((t > TOL_MAX) ? TOL_MAX : t);
	endfunction
endpackage

//--- dce_smooth_if.sv
// Purpose: carries smoothed channel values between the smoother and top
// Assumes: one pair of 16-bit values
// Notes: valid pulses once per finished averaging window
interface dce_smooth_if;
	logic [15:0] avg_a;
	logic [15:0] avg_b;
	logic avg_valid;
	logic [1:0] depth;
	logic restart;
	modport src (output avg_a, avg_b, avg_valid, input depth, restart);
	modport dst (input avg_a, avg_b, avg_valid, output depth, restart);
endinterface

//--- dce_smoother.sv
// Purpose: averages both channels over 1, 4, 16 or 64 conversions
// Assumes: sample strobe marks one conversion per channel
// Notes: restart flushes the running sum
module dce_smoother import dce_pkg::*; (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic sample_valid,
	input wire logic [15:0] sample_a,
	input wire logic [15:0] sample_b,
	dce_smooth_if.src sm
);
	logic [21:0] sum_a, sum_b, next_sum_a, next_sum_b;
	logic [5:0] cnt, next_cnt;
	logic [15:0] avg_a, avg_b, next_avg_a, next_avg_b;
	logic vld, next_vld;
	logic [5:0] last;
	logic [21:0] ta, tb;

	// ==========================================================
	// window accumulation; shift by 2*depth gives the mean
	always_comb begin
		last = 6'((7'h01 << (2 * sm.depth)) - 7'h01);
		next_sum_a = sum_a;
		next_sum_b = sum_b;
		next_cnt = cnt;
		next_avg_a = avg_a;
		next_avg_b = avg_b;
		next_vld = 1'b0;
		ta = sum_a + 22'(sample_a);
		tb = sum_b + 22'(sample_b);
		if (sm.restart) begin
			next_sum_a = '0;
			next_sum_b = '0;
			next_cnt = '0;
		end else if (sample_valid) begin
			if (cnt == last) begin
				next_avg_a = 16'(ta >> (2 * sm.depth));
				next_avg_b = 16'(tb >> (2 * sm.depth));
				next_vld = 1'b1;
				next_sum_a = '0;
				next_sum_b = '0;
				next_cnt = '0;
			end else begin
				next_sum_a = ta;
				next_sum_b = tb;
				next_cnt = cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sum_a <= '0;
			sum_b <= '0;
			cnt <= '0;
			avg_a <= '0;
			avg_b <= '0;
			vld <= 1'b0;
		end else begin
			sum_a <= next_sum_a;
			sum_b <= next_sum_b;
			cnt <= next_cnt;
			avg_a <= next_avg_a;
			avg_b <= next_avg_b;
			vld <= next_vld;
		end
	end

	assign sm.avg_a = avg_a;
	assign sm.avg_b = avg_b;
	assign sm.avg_valid = vld;
endmodule

//--- dual_channel_discrepancy_eval_bench.sv
// Purpose: self-checking bench for the discrepancy evaluator
// Assumes: 10 MHz clock, smoothing of one unless a test sets it
// Notes: register reads are scored by a separate watcher process
module dual_channel_discrepancy_eval_bench import dce_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sample_valid = 1'b0;
	logic [15:0] sample_a = 16'h0000;
	logic [15:0] sample_b = 16'h0000;
	logic channel_fault = 1'b0;
	logic rd_d = 1'b0;
	logic [15:0] va, vb, ev;
	wire logic [15:0] reg_rdata, process_input_image, disc_time_ms, last_value;
	wire logic diag_irq, fault_held;
	wire logic [7:0] irq_count;
	int miscompares = 0;
	int tests_run = 0;
	int seed = 52;
	int cycles = 0;
	logic [15:0] exp_q[$];
	logic [15:0] mask_q[$];
	string name_q[$];
	// tolerance cases: control, tolerance, channel b, outside flag
	logic [15:0] t_ctrl [0:9] = '{16'h0004, 16'h0004, 16'h0006, 16'h0008,
		16'h0008, 16'h000a, 16'h000c, 16'h0004, 16'h0004, 16'h0005};
	logic [15:0] t_tol [0:9] = '{16'h1919, 16'h1919, 16'h1919, 16'h1919,
		16'h1919, 16'h1919, 16'h1919, 16'h1900, 16'h19ff, 16'h1919};
	logic [15:0] t_b [0:9] = '{16'd10499, 16'd10501, 16'd10450, 16'd10200,
		16'd10300, 16'd10200, 16'd10450, 16'd10030, 16'd14500, 16'd10100};
	logic t_out [0:9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0,
		1'b1, 1'b0};

	dce_eval dce_eval_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
		.sample_a(sample_a), .sample_b(sample_b),
		.channel_fault(channel_fault),
		.process_input_image(process_input_image), .diag_irq(diag_irq),
		.fault_held(fault_held));
	dce_ctrl_model dce_ctrl_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.process_input_image(process_input_image), .diag_irq(diag_irq),
		.disc_time_ms(disc_time_ms), .irq_count(irq_count),
		.last_value(last_value));

	// ==========================================================
	// clock and shared tasks
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one-cycle write strobe; the closing edge keeps a gap before the next
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// read: the expectation waits in the queue for the watcher
	task automatic rd(input logic [3:0] a, input string n,
		input logic [15:0] e, input logic [15:0] m);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		name_q.push_back(n);
		exp_q.push_back(e & m);
		mask_q.push_back(m);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask
	// one conversion, then time for averaging and evaluation to land
	task automatic sample(input logic [15:0] a, input logic [15:0] b);
		@(posedge sys_clk);
		sample_a <= a;
		sample_b <= b;
		sample_valid <= 1'b1;
		@(posedge sys_clk);
		sample_valid <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	// ==========================================================
	// watcher and timeout
	// read data stands only in the cycle after the strobe
	always @(posedge sys_clk) begin
		rd_d <= reg_rd;
		cycles <= cycles + 1;
		if (rd_d)
			check(name_q.pop_front(), reg_rdata & mask_q.pop_front(),
				exp_q.pop_front());
		if (cycles == 5000) begin
			miscompares++;
			end_of_test();
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(OFS_TIME, "time", TIME_RST, 16'hffff);
		rd(OFS_CTRL, "ctrl", CTRL_RST, 16'hffff);
		rd(OFS_TOL, "tol", TOL_RST, 16'hffff);
		rd(OFS_VALUE, "value", ERROR_CODE, 16'hffff);
		rd(OFS_STAT, "stat", 16'h0004, 16'h000f);
		rd(4'hf, "unmapped", 16'h0000, 16'hffff);
		$display("reset test done");
		// discrepant right after startup and after a channel fault
		wr(OFS_TIME, disc_time_ms);
		rd(OFS_TIME, "time", 16'd20, 16'hffff);
		sample(16'd10000, 16'd12000);
		rd(OFS_VALUE, "value", ERROR_CODE, 16'hffff);
		rd(OFS_STAT, "stat", 16'h0001, 16'h0003);
		sample(16'd10000, 16'd10000);
		@(posedge sys_clk);
		channel_fault <= 1'b1;
		@(posedge sys_clk);
		channel_fault <= 1'b0;
		sample(16'd10000, 16'd12000);
		rd(OFS_VALUE, "value", ERROR_CODE, 16'hffff);
		$display("fresh test done");
		// tolerance windows, hold of the old value, return to agreement
		for (int i = 0; i < 10; i++) begin
			wr(OFS_CTRL, t_ctrl[i]);
			wr(OFS_TOL, t_tol[i]);
			sample(16'd10000, 16'd10000);
			sample(16'd10000, t_b[i]);
			// discrepant pairs keep the old value, agreeing ones report the pick
			ev = (t_out[i] || !t_ctrl[i][0]) ? 16'd10000 : t_b[i];
			rd(OFS_STAT, "state", {15'h0, t_out[i]}, 16'h0003);
			rd(OFS_VALUE, "value", ev, 16'hffff);
		end
		$display("tolerance test done");
		// random agreeing pairs, lower and higher selection in turn
		wr(OFS_TOL, TOL_RST);
		for (int i = 0; i < 4; i++) begin
			va = 16'h1000 + 16'($random(seed) & 16'h1fff);
			vb = va + 16'($random(seed) & 16'h00ff);
			wr(OFS_CTRL, 16'h0004 | 16'(i % 2));
			sample(vb, va);
			rd(OFS_VALUE, "value", (i % 2) ? vb : va, 16'hffff);
		end
		$display("selection test done");
		// averaging over four conversions
		wr(OFS_CTRL, 16'h0014);
		for (int i = 0; i < 4; i++)
			sample(16'(8000 + 4 * i), 16'(8100 + 4 * i));
		rd(OFS_VALUE, "value", 16'd8006, 16'hffff);
		// averaging over sixty-four conversions, mean truncated
		wr(OFS_CTRL, 16'h0034);
		for (int i = 0; i < 64; i++)
			sample(16'(8000 + i), 16'(8050 + i));
		rd(OFS_VALUE, "value", 16'd8031, 16'hffff);
		wr(OFS_CTRL, 16'h0004);
		$display("smoothing test done");
		// zero time: the first discrepancy expires at once
		wr(OFS_TIME, 16'h0000);
		sample(16'd10000, 16'd10000);
		sample(16'd10000, 16'd12000);
		repeat (5) @(posedge sys_clk);
		check("irq", {8'h00, irq_count}, 16'h0001);
		check("image", last_value, ERROR_CODE);
		check("fault", {15'h0, fault_held}, 16'h0001);
		rd(OFS_STAT, "stat", 16'h000b, 16'h000b);
		wr(OFS_ACK, 16'h0000);
		repeat (2) @(posedge sys_clk);
		check("fault", {15'h0, fault_held}, 16'h0000);
		repeat (3) @(posedge sys_clk);
		$display("expiry test done");
		end_of_test();
	end
endmodule
